/* File: design/input_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous inputs
module input_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             en,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("input_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      dout   <= '0;
    end else if (en) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

/* File: design/motor_chopper_fault_timing.sv */
// Chopper phase sequencer, blanking, over-current and thermal fault latch
module motor_chopper_fault_timing #(
  parameter int unsigned PERIOD = chopper_pkg::CHOP_PERIOD,
  parameter int unsigned BLANK  = chopper_pkg::CHARGE_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                en,
  input  wire logic                chop_ref_oscillator,
  input  wire logic                dc_mode,
  input  wire logic                drive_enable,
  input  wire logic [2:0]          drive_inputs,
  input  wire logic                current_target_reached,
  input  wire logic                overcurrent_sense,
  input  wire logic                thermal_sense,
  output chopper_pkg::drive_e      bridge_drive,
  output logic                     bridge_oe,
  output logic                     blanking,
  output logic                     overcurrent_trip,
  output logic                     thermal_trip
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  generate
    if (PERIOD != chopper_pkg::CHOP_PERIOD || BLANK >= PERIOD || BLANK > 3) begin : g_chk
      $error("motor_chopper_fault_timing: unsupported PERIOD or BLANK");
    end
  endgenerate

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [7:0] raw;
  logic [7:0] syn;
  assign raw = {chop_ref_oscillator, dc_mode, drive_enable, drive_inputs,
                current_target_reached, overcurrent_sense};

  input_sync #(.WIDTH(8)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .en   (en),
    .din  (raw),
    .dout (syn)
  );

  logic thermal_s1_q;
  logic thermal_s2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thermal_s1_q <= 1'b0;
      thermal_s2_q <= 1'b0;
    end else if (en) begin
      thermal_s1_q <= thermal_sense;
      thermal_s2_q <= thermal_s1_q;
    end
  end

  logic       osc_s;
  logic       dc_s;
  logic       ena_s;
  logic [2:0] in_s;
  logic       target_s;
  logic       oc_s;
  assign osc_s    = syn[7];
  assign dc_s     = syn[6];
  assign ena_s    = syn[5];
  assign in_s     = syn[4:2];
  assign target_s = syn[1];
  assign oc_s     = syn[0];

  // ****************************************
  // Sequencer state
  // ****************************************
  logic                osc_prev_q, osc_prev_d;
  logic [2:0]          phase_q, phase_d;
  logic [2:0]          in_prev_q, in_prev_d;
  logic [1:0]          blank_q, blank_d;
  logic [2:0]          mask_q, mask_d;
  logic [3:0]          oc_cnt_q, oc_cnt_d;
  logic                target_hit_q, target_hit_d;
  logic                oc_trip_q, oc_trip_d;
  logic                th_trip_q, th_trip_d;
  chopper_pkg::drive_e drive_q, drive_d;
  logic                oe_q, oe_d;
  logic                blanking_q, blanking_d;

  logic tick;
  logic in_change;
  logic charge_start;
  assign tick         = osc_s && !osc_prev_q;
  assign in_change    = (in_s != in_prev_q);
  assign charge_start = tick && (phase_q == 3'h7);

  always_comb begin
    osc_prev_d   = osc_s;
    in_prev_d    = in_s;
    phase_d      = phase_q;
    blank_d      = blank_q;
    mask_d       = mask_q;
    oc_cnt_d     = oc_cnt_q;
    target_hit_d = target_hit_q;
    oc_trip_d    = oc_trip_q;
    th_trip_d    = th_trip_q;
    drive_d      = drive_q;
    oe_d         = oe_q;

    // Period counter
    if (tick) begin
      phase_d = phase_q + 3'h1;
    end

    // Target reached latches once per period, a hit at period start wins
    if (target_s && blank_q == 2'h0) begin
      target_hit_d = 1'b1;
    end else if (charge_start) begin
      target_hit_d = 1'b0;
    end

    // Digital blanking, DC mode only
    if (!dc_s) begin
      blank_d = 2'h0;
    end else if (in_change || charge_start) begin
      blank_d = 2'(BLANK);
    end else if (tick && blank_q != 2'h0) begin
      blank_d = blank_q - 2'h1;
    end

    // Over-current shutdown timer
    if (!oc_s || mask_q != 3'h0) begin
      oc_cnt_d = 4'h0;
    end else if (tick && oc_cnt_q != chopper_pkg::TRIP_COUNT) begin
      oc_cnt_d = oc_cnt_q + 4'h1;
    end

    // Mask after each switching event; a running count is not masked again
    if ((in_change || charge_start) && oc_cnt_d == 4'h0) begin
      mask_d = chopper_pkg::MASK_COUNT;
    end else if (tick && mask_q != 3'h0) begin
      mask_d = mask_q - 3'h1;
    end
    if (oc_cnt_q == chopper_pkg::TRIP_COUNT) begin
      oc_trip_d = 1'b1;
    end
    if (thermal_s2_q) begin
      th_trip_d = 1'b1;
    end

    // Phase selection: charge, slow, fast
    if (th_trip_q || oc_trip_q || !ena_s) begin
      drive_d = chopper_pkg::DRIVE_OFF;
      oe_d    = 1'b0;
    end else if (phase_q >= chopper_pkg::FAST_START) begin
      drive_d = chopper_pkg::DRIVE_FAST;
      oe_d    = 1'b1;
    end else if (blank_q != 2'h0 || (dc_s && phase_q < 3'(BLANK))) begin
      drive_d = chopper_pkg::DRIVE_CHARGE;
      oe_d    = 1'b1;
    end else if (target_hit_q || target_s) begin
      drive_d = chopper_pkg::DRIVE_SLOW;
      oe_d    = 1'b1;
    end else begin
      drive_d = chopper_pkg::DRIVE_CHARGE;
      oe_d    = 1'b1;
    end
    blanking_d = (blank_d != 2'h0);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_prev_q   <= 1'b0;
      in_prev_q    <= 3'h0;
      phase_q      <= chopper_pkg::PHASE_RESET;
      blank_q      <= 2'h0;
      mask_q       <= 3'h0;
      oc_cnt_q     <= 4'h0;
      target_hit_q <= 1'b0;
      oc_trip_q    <= 1'b0;
      th_trip_q    <= 1'b0;
      drive_q      <= chopper_pkg::DRIVE_OFF;
      oe_q         <= 1'b0;
      blanking_q   <= 1'b0;
    end else if (en) begin
      osc_prev_q   <= osc_prev_d;
      in_prev_q    <= in_prev_d;
      phase_q      <= phase_d;
      blank_q      <= blank_d;
      mask_q       <= mask_d;
      oc_cnt_q     <= oc_cnt_d;
      target_hit_q <= target_hit_d;
      oc_trip_q    <= oc_trip_d;
      th_trip_q    <= th_trip_d;
      drive_q      <= drive_d;
      oe_q         <= oe_d;
      blanking_q   <= blanking_d;
    end
  end

  assign bridge_drive     = drive_q;
  assign bridge_oe        = oe_q;
  assign blanking         = blanking_q;
  assign overcurrent_trip = oc_trip_q;
  assign thermal_trip     = th_trip_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_thermal_off_hiz: assert property (@(posedge clk) disable iff (!nrst)
    en && th_trip_q |=> !oe_q && drive_q == chopper_pkg::DRIVE_OFF)
    else $error("thermal trip did not turn bridge off");

  a_thermal_latched: assert property (@(posedge clk) disable iff (!nrst)
    th_trip_q |=> th_trip_q)
    else $error("thermal trip released before reset");

  a_oc_off_all: assert property (@(posedge clk) disable iff (!nrst)
    en && oc_trip_q |=> !oe_q)
    else $error("over-current trip did not turn bridge off");

  a_oc_latched: assert property (@(posedge clk) disable iff (!nrst)
    oc_trip_q |=> oc_trip_q)
    else $error("over-current trip released before reset");

  a_mask_no_count: assert property (@(posedge clk) disable iff (!nrst)
    en && mask_q != 3'h0 |=> oc_cnt_q == 4'h0)
    else $error("over-current counted inside mask window");

  a_oc_trip_time: assert property (@(posedge clk) disable iff (!nrst)
    en && $rose(oc_trip_q) |-> $past(oc_cnt_q) == chopper_pkg::TRIP_COUNT)
    else $error("over-current trip before four cycles");

  a_phase_step: assert property (@(posedge clk) disable iff (!nrst)
    en && tick |=> phase_q == $past(phase_q) + 3'h1)
    else $error("period counter did not advance");

  a_fast_tail: assert property (@(posedge clk) disable iff (!nrst)
    en && !th_trip_q && !oc_trip_q && ena_s && phase_q >= chopper_pkg::FAST_START
    |=> drive_q == chopper_pkg::DRIVE_FAST)
    else $error("fast decay missing in last counts");

  a_step_noblank: assert property (@(posedge clk) disable iff (!nrst)
    en && !dc_s |=> blank_q == 2'h0)
    else $error("digital blanking in stepper mode");

  a_timer_restart: assert property (@(posedge clk) disable iff (!nrst)
    en && !oc_s |=> oc_cnt_q == 4'h0)
    else $error("over-current timer did not restart");

endmodule

/* File: shared/chopper_pkg.sv */
// Shared constants for the chopper timing and fault latch block
package chopper_pkg;

  // ****************************************
  // Chopping period
  // ****************************************
  localparam int unsigned CHOP_PERIOD   = 8;
  localparam int unsigned CHARGE_CYCLES = 3;
  localparam int unsigned FAST_CYCLES   = 3;
  localparam logic [2:0]  FAST_START    = 3'h5;
  localparam logic [2:0]  PHASE_RESET   = 3'h0;

  // ****************************************
  // Over-current timing, in oscillator cycles
  // ****************************************
  localparam int unsigned MASK_CYCLES   = 4;
  localparam int unsigned TRIP_MIN      = 4;
  localparam int unsigned TRIP_MAX      = 8;
  localparam logic [3:0]  TRIP_COUNT    = 4'h4;
  localparam logic [2:0]  MASK_COUNT    = 3'h4;

  // ****************************************
  // Bridge drive codes
  // ****************************************
  typedef enum logic [1:0] {
    DRIVE_OFF,
    DRIVE_CHARGE,
    DRIVE_SLOW,
    DRIVE_FAST
  } drive_e;

endpackage

/* File: verification/motor_load_model.sv */
// Model of the motor winding, sense resistor and reference oscillator
module motor_load_model #(
  parameter int OSC_HALF = 4,
  parameter int TARGET   = 20
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                short_cmd,
  input  wire chopper_pkg::drive_e bridge_drive,
  input  wire logic                bridge_oe,
  output logic                     chop_ref_oscillator,
  output logic                     current_target_reached,
  output logic                     overcurrent_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Oscillator and winding current
  // ****************************************
  int div = 0;
  int level = 0;
  initial chop_ref_oscillator = 1'b0;
  always @(posedge clk) begin
    if (div == OSC_HALF - 1) begin
      div <= 0;
      chop_ref_oscillator <= ~chop_ref_oscillator;
    end else begin
      div <= div + 1;
    end
    if (!nrst) begin
      level <= 0;
    end else if (bridge_oe && bridge_drive == chopper_pkg::DRIVE_CHARGE) begin
      level <= level + 1;
    end else if (level > 0) begin
      level <= level - 1;
    end
  end
  assign current_target_reached = (level >= TARGET);
  // Short only draws current while the bridge drives
  assign overcurrent_sense = short_cmd && bridge_oe;
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the chopper timing and fault latch block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, nrst, en, short_cmd, dc_mode, drive_enable, thermal_sense;
  logic [2:0]          drive_inputs;
  logic                chop_ref_oscillator, current_target_reached, overcurrent_sense;
  chopper_pkg::drive_e bridge_drive;
  logic                bridge_oe, blanking, overcurrent_trip, thermal_trip;
  int                  fail_count, comparisons, n, m, c, s;

  motor_chopper_fault_timing i_motor_chopper_fault_timing (
    .clk(clk), .nrst(nrst), .en(en), .chop_ref_oscillator(chop_ref_oscillator),
    .dc_mode(dc_mode), .drive_enable(drive_enable), .drive_inputs(drive_inputs),
    .current_target_reached(current_target_reached),
    .overcurrent_sense(overcurrent_sense), .thermal_sense(thermal_sense),
    .bridge_drive(bridge_drive), .bridge_oe(bridge_oe), .blanking(blanking),
    .overcurrent_trip(overcurrent_trip), .thermal_trip(thermal_trip));
  motor_load_model i_motor_load_model (
    .clk(clk), .nrst(nrst), .short_cmd(short_cmd), .bridge_drive(bridge_drive),
    .bridge_oe(bridge_oe), .chop_ref_oscillator(chop_ref_oscillator),
    .current_target_reached(current_target_reached),
    .overcurrent_sense(overcurrent_sense));

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic wt(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic count(int k);
    n = 0; m = 0; c = 0; s = 0;
    repeat (k) begin
      @(negedge clk);
      n += (bridge_drive === chopper_pkg::DRIVE_FAST);
      m += (blanking === 1'b1);
      c += (bridge_drive === chopper_pkg::DRIVE_CHARGE);
      s += (bridge_drive === chopper_pkg::DRIVE_SLOW);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    nrst = 1'b0;
    wt(20);
    nrst = 1'b1;
    wt(2);
    check("oc_trip", overcurrent_trip, 8'h00);
    check("th_trip", thermal_trip, 8'h00);
    check("drive", bridge_drive, 8'h00);
  endtask
  task automatic t_period;
    dc_mode = 1'b0;
    drive_enable = 1'b1;
    wt(200);
    count(128);
    check("fast_cycles", n[7:0], 8'h30);
    check("stepper_blank", m[7:0], 8'h00);
    check("charge_seen", c > 0, 8'h01);
    check("slow_seen", s > 0, 8'h01);
    check("oe", bridge_oe, 8'h01);
  endtask
  task automatic t_freeze;
    chopper_pkg::drive_e held;
    held = bridge_drive;
    en = 1'b0;
    wt(44);
    check("freeze_drive", bridge_drive, held);
    en = 1'b1;
    wt(40);
    check("run_oe", bridge_oe, 8'h01);
  endtask
  task automatic t_enable;
    drive_enable = 1'b0;
    wt(10);
    check("oe_off", bridge_oe, 8'h00);
    drive_enable = 1'b1;
    wt(10);
  endtask
  task automatic t_dc;
    dc_mode = 1'b1;
    wt(100);
    drive_inputs = 3'h1;
    count(64);
    check("dc_blank", m >= 17, 8'h01);
    check("dc_charge", c >= 17, 8'h01);
    dc_mode = 1'b0;
    wt(100);
  endtask
  task automatic t_glitch;
    repeat (3) begin
      short_cmd = 1'b1;
      wt(24);
      short_cmd = 1'b0;
      wt(12);
    end
    wt(40);
    check("no_trip", overcurrent_trip, 8'h00);
  endtask
  task automatic t_ovc;
    short_cmd = 1'b1;
    n = 0;
    while (overcurrent_trip !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("trip_min", n >= 25, 8'h01);
    check("trip_max", n <= 72, 8'h01);
    wt(2);
    check("oc_oe", bridge_oe, 8'h00);
    short_cmd = 1'b0;
    drive_inputs = 3'h2;
    wt(100);
    check("oc_latch", overcurrent_trip, 8'h01);
    check("oc_hold", bridge_oe, 8'h00);
  endtask
  task automatic t_thermal;
    wt(100);
    thermal_sense = 1'b1;
    wt(8);
    check("th_set", thermal_trip, 8'h01);
    check("th_oe", bridge_oe, 8'h00);
    thermal_sense = 1'b0;
    drive_inputs = 3'h4;
    wt(100);
    check("th_latch", thermal_trip, 8'h01);
    check("th_drive", bridge_drive, 8'h00);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    fail_count = 0;
    comparisons = 0;
    nrst = 1'b0;
    en = 1'b1;
    short_cmd = 1'b0;
    dc_mode = 1'b0;
    drive_enable = 1'b0;
    thermal_sense = 1'b0;
    drive_inputs = 3'h0;
    t_reset;
    t_period;
    t_freeze;
    t_enable;
    t_dc;
    t_glitch;
    t_ovc;
    t_reset;
    t_thermal;
    t_reset;
    test_done;
  end
  initial begin
    #(20000 * 50);
    fail_count++;
    test_done;
  end
endmodule
